// ### shared/load_exec_pkg.sv
// Constants and types shared by the byte/halfword load execution block
// Overview of operation
// RULE1: Opcodes 34, 35 are byte displacement loads
// RULE2: Opcodes 42, 43 are halfword displacement loads
// RULE3: Under 31, 119 and 87 index byte
// RULE4: Under 31, 375 and 343 index halfword
// RULE5: Displacement sign-extended to 32, added to base
// RULE6: Non-update forms use zero when base field zero
// RULE7: Update forms always read base register
// RULE8: Indexed forms add index register to base
// RULE9: Byte load zero-fills upper 24 bits
// RULE10: Halfword load sign-extends to 32 bits
// RULE11: Update forms write address into base register
// RULE12: Update with base zero or target: bounded
// RULE13: Nonzero reserved bits in indexed: bounded result
// RULE14: User relocated no-access zone raises storage exception
// RULE15: Relocated access without translation raises TLB miss
// RULE16: Exception suppresses target and base writes
package load_exec_pkg;
  localparam int unsigned DATA_W       = 32;  // Register width
  localparam int unsigned REG_IDX_W    = 5;   // Register index width
  localparam logic [5:0]  OP_BYTE_D    = 6'h22; // Primary 34
  localparam logic [5:0]  OP_BYTE_DU   = 6'h23; // Primary 35
  localparam logic [5:0]  OP_HALF_D    = 6'h2a; // Primary 42
  localparam logic [5:0]  OP_HALF_DU   = 6'h2b; // Primary 43
  localparam logic [5:0]  OP_EXT       = 6'h1f; // Primary 31
  localparam logic [9:0]  XO_BYTE_XU   = 10'h077; // Extended 119
  localparam logic [9:0]  XO_BYTE_X    = 10'h057; // Extended 87
  localparam logic [9:0]  XO_HALF_XU   = 10'h177; // Extended 375
  localparam logic [9:0]  XO_HALF_X    = 10'h157; // Extended 343
  localparam logic [4:0]  REG_ZERO     = 5'h00;   // Base field meaning literal zero
  localparam logic [31:0] WORD_RESET   = 32'h0000_0000; // Data outputs after reset
  // Execution sequence states
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} exec_state_e;
endpackage : load_exec_pkg

// ### hw/load_ext_unit.sv
// Extension unit: registers the fetched data formatted as byte or halfword
`timescale 1ns/1ps
`default_nettype none
module load_ext_unit
  import load_exec_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Capture request
  input  wire logic              cap_i,
  input  wire logic              half_i,
  input  wire logic [15:0]       raw_i,
  // Formatted result
  output logic [DATA_W-1:0]      ext_o
);
  // Byte takes zero fill, halfword takes its sign
  wire logic [DATA_W-1:0] byte_fmt = {24'h00_0000, raw_i[7:0]};          // [RULE9]
  wire logic [DATA_W-1:0] half_fmt = {{16{raw_i[15]}}, raw_i};           // [RULE10]
  wire logic [DATA_W-1:0] fmt      = half_i ? half_fmt : byte_fmt;

  // Result register, held until the next capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) ext_o <= WORD_RESET;
    else if (cap_i) ext_o <= fmt;
  end
endmodule : load_ext_unit
`default_nettype wire

// ### hw/byte_half_load_exec.sv
// Decode and execute for byte zero-extending and halfword sign-extending loads
`timescale 1ns/1ps
`default_nettype none
module byte_half_load_exec
  import load_exec_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Instruction issue
  input  wire logic                          issue_i,
  input  wire logic [31:0]                   instr_i,
  output logic                               busy_o,
  output logic                               illegal_o,
  // Register file read ports (same clock, data valid combinationally)
  output logic [load_exec_pkg::REG_IDX_W-1:0] base_idx_o,
  output logic [load_exec_pkg::REG_IDX_W-1:0] index_idx_o,
  input  wire logic [load_exec_pkg::DATA_W-1:0] base_data_i,
  input  wire logic [load_exec_pkg::DATA_W-1:0] index_data_i,
  // Data access unit
  output logic                               mem_req_o,
  output logic                               mem_half_o,
  output logic [load_exec_pkg::DATA_W-1:0]   effective_addr_o,
  input  wire logic                          mem_ack_i,
  input  wire logic [15:0]                   mem_data_i,
  // Translation and protection status
  input  wire logic                          user_mode_i,
  input  wire logic                          data_reloc_i,
  input  wire logic                          zone_no_access_i,
  input  wire logic                          tlb_hit_i,
  // Register file write ports
  output logic                               target_we_o,
  output logic [load_exec_pkg::REG_IDX_W-1:0] target_idx_o,
  output logic [load_exec_pkg::DATA_W-1:0]   target_data_o,
  output logic                               base_we_o,
  output logic [load_exec_pkg::REG_IDX_W-1:0] base_wr_idx_o,
  output logic [load_exec_pkg::DATA_W-1:0]   base_wr_data_o,
  // Exceptions
  output logic                               dsi_exc_o,
  output logic                               dtlb_miss_o
);
  import load_exec_pkg::*;

  // Load sequence seen from the ports:
  //   edge c0     word taken, address and operands captured
  //   after c0    busy and request rise, or one fault pulse and no request
  //   edge cN     acknowledge sampled, returned data formatted and registered
  //   after cN    write pulses for target and, on update forms, base
  //   after cN+1  busy falls and the next word may be taken
  // Register reads are combinational at issue, so the register file must
  // present contents for the live fields in the same cycle.

  // Instruction field split, big-endian bit 0 is the msb
  // Target and base fields sit in place for every form; only the low half
  // means either a displacement or an index field plus extended opcode
  wire logic [5:0]  prim_op    = instr_i[31:26];
  wire logic [4:0]  target_fld = instr_i[25:21];
  wire logic [4:0]  base_reg_field  = instr_i[20:16];
  wire logic [4:0]  index_reg_field = instr_i[15:11];
  wire logic [9:0]  ext_op     = instr_i[10:1];
  wire logic [15:0] offset_imm = instr_i[15:0];

  // Opcode recognition
  // Displacement forms decode on the primary opcode alone; indexed forms need
  // the extended opcode as well, and the low bit of the word is ignored
  wire logic dec_byte_d  = (prim_op == OP_BYTE_D);                           // [RULE1]
  wire logic dec_byte_du = (prim_op == OP_BYTE_DU);                          // [RULE1]
  wire logic dec_half_d  = (prim_op == OP_HALF_D);                           // [RULE2]
  wire logic dec_half_du = (prim_op == OP_HALF_DU);                          // [RULE2]
  wire logic is_ext      = (prim_op == OP_EXT);
  wire logic dec_byte_xu = is_ext && (ext_op == XO_BYTE_XU);                 // [RULE3]
  wire logic dec_byte_x  = is_ext && (ext_op == XO_BYTE_X);                  // [RULE3]
  wire logic dec_half_xu = is_ext && (ext_op == XO_HALF_XU);                 // [RULE4]
  wire logic dec_half_x  = is_ext && (ext_op == XO_HALF_X);                  // [RULE4]

  // Class of the decoded load
  // Update and index flags steer base selection, addend and writeback
  wire logic dec_valid  = dec_byte_d | dec_byte_du | dec_half_d | dec_half_du
                        | dec_byte_xu | dec_byte_x | dec_half_xu | dec_half_x;
  wire logic dec_half   = dec_half_d | dec_half_du | dec_half_xu | dec_half_x;
  wire logic dec_update = dec_byte_du | dec_half_du | dec_byte_xu | dec_half_xu;
  wire logic dec_index  = dec_byte_xu | dec_byte_x | dec_half_xu | dec_half_x;
  // Reserved bit 31 and base/target overlaps are not checked: result bounded
  // but undefined, no program exception, matching the cheaper decoder [RULE12] [RULE13]

  // Base selection: literal zero only for non-update forms with field zero
  // Update forms read the named register even for field zero, so the address
  // written back is always the one used for the access
  wire logic zero_base = !dec_update && (base_reg_field == REG_ZERO);       // [RULE6] [RULE7]
  wire logic [DATA_W-1:0] base_val = zero_base ? WORD_RESET : base_data_i;
  // Addend is index register or sign-extended displacement
  wire logic [DATA_W-1:0] disp_ext = {{16{offset_imm[15]}}, offset_imm};   // [RULE5]
  wire logic [DATA_W-1:0] addend   = dec_index ? index_data_i : disp_ext;  // [RULE8]
  wire logic [DATA_W-1:0] addr_calc = base_val + addend;                    // [RULE5] [RULE8]

  // Access checks evaluated at issue
  // Both use the status inputs as they stand at the issue edge, so the
  // translation side must present them for the offered word in that cycle.
  // Protection means nothing without a valid translation, so the storage
  // fault is masked by the miss
  wire logic chk_tlb_miss = data_reloc_i && !tlb_hit_i;                     // [RULE15]
  wire logic chk_dsi = user_mode_i && data_reloc_i && tlb_hit_i && zone_no_access_i; // [RULE14]
  wire logic take    = issue_i && !busy_o && dec_valid;

  // Sequence state and held operands
  exec_state_e state_reg, state_next;
  logic        upd_reg;                 // Update form in flight
  logic        half_reg;                // Halfword in flight
  logic [4:0]  tgt_reg;                 // Target index
  logic [4:0]  base_fld_reg;            // Base index for update write
  logic        ext_cap;                 // Capture strobe to extension unit
  logic [DATA_W-1:0] ext_data;          // Formatted load data

  // Next state: a fault ends the load at once, the read waits for ack
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      // Wait for a load word that passes both access checks
      ST_IDLE:  if (take && !chk_tlb_miss && !chk_dsi) state_next = ST_READ;
      // Request stands until the data unit answers
      ST_READ:  if (mem_ack_i) state_next = ST_WRITE;
      // One cycle for the write pulses, then free again
      ST_WRITE: state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end
  // Data stands on the bus only in the acknowledge cycle
  assign ext_cap = (state_reg == ST_READ) && mem_ack_i;

  // State register
  // A reset in mid-load drops the access; no write pulse follows
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) state_reg <= ST_IDLE;
    else       state_reg <= state_next;
  end

  // Operand capture on acceptance
  // Faulting loads capture too, which leaves the failing address visible
  // to whoever handles the exception
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      upd_reg          <= 1'b0;
      half_reg         <= 1'b0;
      tgt_reg          <= REG_ZERO;
      base_fld_reg     <= REG_ZERO;
      effective_addr_o <= WORD_RESET;
    end else if (take) begin
      upd_reg          <= dec_update;
      half_reg         <= dec_half;
      tgt_reg          <= target_fld;
      base_fld_reg     <= base_reg_field;
      effective_addr_o <= addr_calc;
    end
  end

  // Read port indices follow the live instruction
  // Informational only; the reads themselves use the live fields
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      base_idx_o  <= REG_ZERO;
      index_idx_o <= REG_ZERO;
    end else begin
      base_idx_o  <= base_reg_field;
      index_idx_o <= index_reg_field;
    end
  end

  // Status and request outputs, all registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o      <= 1'b0;
      illegal_o   <= 1'b0;
      mem_req_o   <= 1'b0;
      mem_half_o  <= 1'b0;
      dsi_exc_o   <= 1'b0;
      dtlb_miss_o <= 1'b0;
    end else begin
      busy_o      <= (state_next != ST_IDLE);
      // Non-load words are flagged only when the block could have taken them
      illegal_o   <= issue_i && !busy_o && !dec_valid;
      mem_req_o   <= (state_next == ST_READ);
      // Width held for the whole access
      mem_half_o  <= take ? dec_half : mem_half_o;
      // Miss takes priority: no translation means no protection to check
      dtlb_miss_o <= take && chk_tlb_miss;                                   // [RULE15]
      dsi_exc_o   <= take && chk_dsi;                                         // [RULE14]
    end
  end

  // Writeback only after a clean read; faulted loads never get here
  // Indices and data follow every cycle; only the enables qualify them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      target_we_o    <= 1'b0;
      target_idx_o   <= REG_ZERO;
      base_we_o      <= 1'b0;
      base_wr_idx_o  <= REG_ZERO;
      base_wr_data_o <= WORD_RESET;
    end else begin
      target_we_o    <= ext_cap;                                              // [RULE16]
      target_idx_o   <= tgt_reg;
      base_we_o      <= ext_cap && upd_reg;                                   // [RULE11] [RULE16]
      base_wr_idx_o  <= base_fld_reg;
      base_wr_data_o <= effective_addr_o;                                     // [RULE11]
    end
  end
  // Load data comes straight from the extension unit's register, so the
  // write pulse and the data appear on the same edge
  assign target_data_o = ext_data;

  // Byte or halfword formatting of the returned data
  // The unit sees the raw bus every cycle but loads it only on the strobe
  load_ext_unit u_ext (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cap_i  (ext_cap),
    .half_i (half_reg),
    .raw_i  (mem_data_i),
    .ext_o  (ext_data)
  );
endmodule : byte_half_load_exec
`default_nettype wire

// ### test/byte_half_load_exec_props.sv
// Port assertions for the byte/halfword load block
`timescale 1ns/1ps
`default_nettype none
module byte_half_load_exec_props
  import load_exec_pkg::*;
(
  input wire logic        clk_i, rst_i, issue_i, busy_o, illegal_o, mem_req_o, mem_half_o, mem_ack_i,
  input wire logic        user_mode_i, data_reloc_i, zone_no_access_i, tlb_hit_i,
  input wire logic        target_we_o, base_we_o, dsi_exc_o, dtlb_miss_o,
  input wire logic [15:0] mem_data_i,
  input wire logic [31:0] instr_i, base_data_i, index_data_i, effective_addr_o, target_data_o, base_wr_data_o
);
  wire [5:0] op = instr_i[31:26];  // Primary opcode
  wire [9:0] xo = instr_i[10:1];   // Extended opcode
  wire xf = op == OP_EXT && (xo == XO_BYTE_X || xo == XO_BYTE_XU || xo == XO_HALF_X || xo == XO_HALF_XU);
  wire ld = xf || op == OP_BYTE_D || op == OP_BYTE_DU || op == OP_HALF_D || op == OP_HALF_DU;
  wire hf = xf ? xo[8] : op[3];    // Width bit differs between the codes
  wire up = xf ? xo[5] : op[0];    // Update bit differs between the codes
  wire acc = issue_i && !busy_o && ld;
  wire flt = data_reloc_i && (!tlb_hit_i || user_mode_i && zone_no_access_i);
  // Expected address; zero base only for non-update forms
  wire [31:0] exp_addr = ((!up && instr_i[20:16] == 5'h00) ? 32'h0 : base_data_i)
                 + (xf ? index_data_i : {{16{instr_i[15]}}, instr_i[15:0]});
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take; acc && !flt; endsequence
  sequence s_ack; mem_req_o && mem_ack_i; endsequence
  a_addr_formed: assert property (s_take |=> effective_addr_o == $past(exp_addr))
    else $error("effective address wrong");
  a_width_decode: assert property (s_take |=> mem_req_o && !illegal_o && mem_half_o == $past(hf))
    else $error("load decode wrong");
  a_illegal_word: assert property (issue_i && !busy_o && !ld |=> illegal_o && !mem_req_o)
    else $error("non-load accepted");
  a_tlb_miss: assert property (acc && data_reloc_i && !tlb_hit_i |=> dtlb_miss_o && !dsi_exc_o)
    else $error("missing translation fault");
  a_storage_exc: assert property (acc && data_reloc_i && tlb_hit_i && user_mode_i && zone_no_access_i |=> dsi_exc_o)
    else $error("missing storage fault");
  a_no_false_exc: assert property (s_take |=> !dsi_exc_o && !dtlb_miss_o)
    else $error("spurious fault");
  a_fault_quiet: assert property (dsi_exc_o || dtlb_miss_o |-> (!target_we_o && !base_we_o) [*2])
    else $error("write after fault");
  a_byte_zero: assert property ((s_ack and !mem_half_o) |=> target_we_o && target_data_o == {24'h0, $past(mem_data_i[7:0])})
    else $error("byte not zero-extended");
  a_half_sign: assert property ((s_ack and mem_half_o) |=> target_we_o
    && target_data_o == {{16{$past(mem_data_i[15])}}, $past(mem_data_i)})
    else $error("halfword not sign-extended");
  a_base_update: assert property (base_we_o |-> target_we_o && base_wr_data_o == effective_addr_o)
    else $error("base update wrong");
endmodule : byte_half_load_exec_props
bind byte_half_load_exec byte_half_load_exec_props chk (.*);
`default_nettype wire

// ### test/load_mem_model.sv
// Register file and data-access partner for the load block
`timescale 1ns/1ps
`default_nettype none
module load_mem_model (
  input  wire logic        clk_i, rst_i, mem_req_i,
  input  wire logic [31:0] instr_i, addr_i,
  input  wire logic [3:0]  lat_i,
  output logic             ack_o,
  output logic [31:0]      base_o, index_o,
  output logic [15:0]      data_o
);
  logic [3:0] cnt_reg;  // Cycles waited
  logic       done_reg; // Request already answered
  // Register contents follow the index, so r0 is not zero
  assign base_o  = {instr_i[20:16], 27'h0000f80};
  assign index_o = {instr_i[15:11], 27'h0000f80};
  // Data valid only with ack; inverted elsewhere so stale use shows
  assign data_o = ack_o ? addr_i[15:0] ^ 16'h8181 : addr_i[15:0] ^ 16'h7e7e;
  // One ack after lat_i waiting cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {ack_o, done_reg, cnt_reg} <= '0;
    end else begin
      ack_o    <= mem_req_i && !done_reg && cnt_reg == lat_i;
      done_reg <= mem_req_i && (done_reg || cnt_reg == lat_i);
      cnt_reg  <= mem_req_i ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule : load_mem_model
`default_nettype wire

// ### test/byte_half_load_exec_test.sv
// Self-checking bench for the byte/halfword load block
`timescale 1ns/1ps
`default_nettype none
module byte_half_load_exec_test;
  import load_exec_pkg::*;
  logic        clk_i = 0, rst_i = 1, issue_i = 0, user_mode_i = 0;
  logic        data_reloc_i = 0, zone_no_access_i = 0, tlb_hit_i = 1;
  logic [31:0] instr_i = '0;
  logic [3:0]  lat = '0;
  logic        busy_o, illegal_o, mem_req_o, mem_half_o, mem_ack_i, target_we_o, base_we_o, dsi_exc_o, dtlb_miss_o;
  logic [4:0]  target_idx_o, base_wr_idx_o, base_idx_o, index_idx_o;
  logic [15:0] mem_data_i;
  logic [31:0] base_data_i, index_data_i, effective_addr_o, target_data_o, base_wr_data_o;
  int          n_errors = 0, n_checks = 0, cyc = 0;
  byte_half_load_exec uut (.*);
  load_mem_model pm (.clk_i, .rst_i, .mem_req_i(mem_req_o), .instr_i, .addr_i(effective_addr_o), .lat_i(lat),
    .ack_o(mem_ack_i), .base_o(base_data_i), .index_o(index_data_i), .data_o(mem_data_i));
  always #5 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      stop_test;
    end
  end
  function automatic logic [31:0] gv(input logic [4:0] i);
    return {i, 27'h0000f80};
  endfunction : gv
  function automatic logic [31:0] xi(input logic [4:0] d, a, b, input logic [9:0] x);
    return {OP_EXT, d, a, b, x, 1'b0};
  endfunction : xi
  task chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Issue one load and judge its whole answer; flt 1 miss, 2 storage
  task automatic do_load(input logic [31:0] ins, addr, input logic hf, upd, input logic [1:0] flt);
    logic [15:0] d;
    int          n;
    d = addr[15:0] ^ 16'h8181;
    @(negedge clk_i);
    instr_i = ins;
    issue_i = 1;
    user_mode_i = 1;
    data_reloc_i = flt != 0;
    tlb_hit_i = flt != 1;
    zone_no_access_i = flt != 1;
    @(negedge clk_i);
    issue_i = 0;
    chk("miss", {31'h0, flt == 1}, {31'h0, dtlb_miss_o});
    chk("dsi", {31'h0, flt == 2}, {31'h0, dsi_exc_o});
    chk("ridx", {22'h0, ins[20:11]}, {22'h0, base_idx_o, index_idx_o});
    if (flt == 0) begin
      chk("addr", addr, effective_addr_o);
      chk("half", {31'h0, hf}, {31'h0, mem_half_o});
      n = 0;
      while (target_we_o !== 1'b1 && n < 40) begin
        @(negedge clk_i);
        n++;
      end
      chk("wen", 32'h1, {31'h0, target_we_o});
      chk("data", hf ? {{16{d[15]}}, d} : {24'h0, d[7:0]}, target_data_o);
      chk("tidx", {27'h0, ins[25:21]}, {27'h0, target_idx_o});
      chk("bwe", {31'h0, upd}, {31'h0, base_we_o});
      if (upd) chk("bdat", addr, base_wr_data_o);
      if (upd) chk("bidx", {27'h0, ins[20:16]}, {27'h0, base_wr_idx_o});
      @(negedge clk_i);
    end else chk("twe", 32'h0, {31'h0, target_we_o});
    chk("busy", 32'h0, {31'h0, busy_o});
  endtask : do_load
  task t_disp; // Displacement forms, prompt answer
    lat = 4'h0;
    do_load({OP_BYTE_D, 5'd3, 5'd0, 16'h8004}, 32'hffff8004, 0, 0, 0);
    do_load({OP_BYTE_DU, 5'd4, 5'd2, 16'h0010}, gv(2) + 32'h10, 0, 1, 0);
    do_load({OP_HALF_D, 5'd5, 5'd0, 16'h8100}, 32'hffff8100, 1, 0, 0);
    do_load({OP_HALF_DU, 5'd6, 5'd0, 16'hfff0}, gv(0) - 32'h10, 1, 1, 0);
  endtask : t_disp
  task t_idx; // Indexed forms, slow answer
    lat = 4'h3;
    do_load(xi(5'd8, 5'd0, 5'd7, XO_BYTE_X), gv(7), 0, 0, 0);
    do_load(xi(5'd9, 5'd1, 5'd2, XO_BYTE_XU), gv(1) + gv(2), 0, 1, 0);
    do_load(xi(5'd10, 5'd3, 5'd4, XO_HALF_XU), gv(3) + gv(4), 1, 1, 0);
    do_load(xi(5'd11, 5'd0, 5'd12, XO_HALF_X), gv(12), 1, 0, 0);
  endtask : t_idx
  task t_fault; // Back-to-back faults on update forms
    do_load({OP_BYTE_DU, 5'd1, 5'd2, 16'h0004}, 32'h0, 0, 1, 1);
    do_load(xi(5'd3, 5'd4, 5'd5, XO_HALF_XU), 32'h0, 1, 1, 2);
  endtask : t_fault
  task t_reset; // Reset drops a load in flight, then a clean load follows
    lat = 4'h3;
    @(negedge clk_i);
    instr_i = {OP_HALF_DU, 5'd7, 5'd1, 16'h0002};
    issue_i = 1;
    data_reloc_i = 0;
    @(negedge clk_i);
    issue_i = 0;
    rst_i = 1;
    @(negedge clk_i);
    chk("rquiet", 32'h0, {28'h0, busy_o, mem_req_o, target_we_o, base_we_o});
    chk("raddr", WORD_RESET, effective_addr_o);
    rst_i = 0;
    do_load({OP_BYTE_D, 5'd2, 5'd5, 16'h0001}, gv(5) + 32'h1, 0, 0, 0);
  endtask : t_reset
  task t_illegal; // Byte-reverse word is not one of the eight
    @(negedge clk_i);
    instr_i = xi(5'd1, 5'd2, 5'd3, 10'h316);
    issue_i = 1;
    @(negedge clk_i);
    issue_i = 0;
    chk("ill", 32'h1, {31'h0, illegal_o});
    chk("req", 32'h0, {31'h0, mem_req_o});
  endtask : t_illegal
  task stop_test;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 0;
    t_disp;
    t_idx;
    t_fault;
    t_reset;
    t_illegal;
    stop_test;
  end
endmodule : byte_half_load_exec_test
`default_nettype wire
